// *** hdl/stp_pkg.sv ***
// Shared constants, state and instruction codes for the SRAM test port.
// Assumes a three-bit instruction register and an externally driven TCK.
package stp_pkg;

  // Register widths and lengths
  localparam int STP_IR_W = 3;
  localparam int STP_ID_W = 32;
  localparam int STP_BSR_LEN = 110;
  // Position of the output bus enable cell in the boundary register
  localparam int STP_HIZ_BIT = 109;

  // Instruction codes
  localparam logic [2:0] STP_I_EXTEST = 3'h0;
  localparam logic [2:0] STP_I_IDCODE = 3'h1;
  localparam logic [2:0] STP_I_SAMPLE_Z = 3'h2;
  localparam logic [2:0] STP_I_SAMPLE = 3'h4;
  localparam logic [2:0] STP_I_BYPASS = 3'h7;

  // Values after reset and fixed capture patterns
  localparam logic [2:0] STP_IR_RESET = STP_I_IDCODE;
  localparam logic [2:0] STP_IR_CAPTURE = 3'h1;
  localparam logic STP_BYPASS_CAPTURE = 1'b0;
  localparam logic STP_HIZ_CELL_RESET = 1'b0;
  // Arbitrary neutral identification value, low bit set as required
  localparam logic [31:0] STP_IDCODE_VAL = 32'h0a5a_5001;

  typedef enum logic [15:0] {
    STP_TLR = 16'h0001,
    STP_RTI = 16'h0002,
    STP_SEL_DR = 16'h0004,
    STP_CAP_DR = 16'h0008,
    STP_SH_DR = 16'h0010,
    STP_EX1_DR = 16'h0020,
    STP_PA_DR = 16'h0040,
    STP_EX2_DR = 16'h0080,
    STP_UPD_DR = 16'h0100,
    STP_SEL_IR = 16'h0200,
    STP_CAP_IR = 16'h0400,
    STP_SH_IR = 16'h0800,
    STP_EX1_IR = 16'h1000,
    STP_PA_IR = 16'h2000,
    STP_EX2_IR = 16'h4000,
    STP_UPD_IR = 16'h8000
  } stp_state_t;

  typedef enum logic [2:0] {
    STP_DR_BYP = 3'h1,
    STP_DR_ID = 3'h2,
    STP_DR_BSR = 3'h4
  } stp_dr_t;

  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } stp_ctl_t;

  // Reserved codes fall back to the bypass cell, a safe one-bit path
  function automatic stp_dr_t stp_dr_select(input logic [2:0] instr);
    case (instr)
      STP_I_IDCODE: stp_dr_select = STP_DR_ID;
      STP_I_EXTEST: stp_dr_select = STP_DR_BSR;
      STP_I_SAMPLE_Z: stp_dr_select = STP_DR_BSR;
      STP_I_SAMPLE: stp_dr_select = STP_DR_BSR;
      default: stp_dr_select = STP_DR_BYP;
    endcase
  endfunction

endpackage

// *** hdl/stp_sync.sv ***
// Two-flop synchroniser for levels entering a clock domain.
// Assumes the input is a level held for at least two destination clocks.
`timescale 1ns/10ps
`default_nettype none
module stp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_level,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] meta;

  // First stage is read only by the second
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      meta <= '0;
      o_level <= '0;
    end else begin
      meta <= i_level;
      o_level <= meta;
    end
  end

endmodule // stp_sync
`default_nettype wire

// *** hdl/stp_fsm.sv ***
// Sixteen-state test port controller, advanced by TMS on rising TCK.
// Assumes i_resetn is already synchronous in release to TCK.
`timescale 1ns/10ps
`default_nettype none
module stp_fsm (
  input wire logic i_tck,
  input wire logic i_resetn,
  input wire logic i_tms,
  output var stp_pkg::stp_state_t o_state,
  output var stp_pkg::stp_ctl_t o_ir,
  output var stp_pkg::stp_ctl_t o_dr
);

  stp_pkg::stp_state_t next_state;

  always_comb begin
    next_state = stp_pkg::STP_TLR;
    case (o_state)
      stp_pkg::STP_TLR:
        next_state = i_tms ? stp_pkg::STP_TLR : stp_pkg::STP_RTI;
      stp_pkg::STP_RTI:
        next_state = i_tms ? stp_pkg::STP_SEL_DR : stp_pkg::STP_RTI;
      stp_pkg::STP_SEL_DR:
        next_state = i_tms ? stp_pkg::STP_SEL_IR : stp_pkg::STP_CAP_DR;
      stp_pkg::STP_CAP_DR:
        next_state = i_tms ? stp_pkg::STP_EX1_DR : stp_pkg::STP_SH_DR;
      stp_pkg::STP_SH_DR:
        next_state = i_tms ? stp_pkg::STP_EX1_DR : stp_pkg::STP_SH_DR;
      stp_pkg::STP_EX1_DR:
        next_state = i_tms ? stp_pkg::STP_UPD_DR : stp_pkg::STP_PA_DR;
      stp_pkg::STP_PA_DR:
        next_state = i_tms ? stp_pkg::STP_EX2_DR : stp_pkg::STP_PA_DR;
      stp_pkg::STP_EX2_DR:
        next_state = i_tms ? stp_pkg::STP_UPD_DR : stp_pkg::STP_SH_DR;
      stp_pkg::STP_UPD_DR:
        next_state = i_tms ? stp_pkg::STP_SEL_DR : stp_pkg::STP_RTI;
      stp_pkg::STP_SEL_IR:
        next_state = i_tms ? stp_pkg::STP_TLR : stp_pkg::STP_CAP_IR;
      stp_pkg::STP_CAP_IR:
        next_state = i_tms ? stp_pkg::STP_EX1_IR : stp_pkg::STP_SH_IR;
      stp_pkg::STP_SH_IR:
        next_state = i_tms ? stp_pkg::STP_EX1_IR : stp_pkg::STP_SH_IR;
      stp_pkg::STP_EX1_IR:
        next_state = i_tms ? stp_pkg::STP_UPD_IR : stp_pkg::STP_PA_IR;
      stp_pkg::STP_PA_IR:
        next_state = i_tms ? stp_pkg::STP_EX2_IR : stp_pkg::STP_PA_IR;
      stp_pkg::STP_EX2_IR:
        next_state = i_tms ? stp_pkg::STP_UPD_IR : stp_pkg::STP_SH_IR;
      stp_pkg::STP_UPD_IR:
        next_state = i_tms ? stp_pkg::STP_SEL_DR : stp_pkg::STP_RTI;
      default:
        next_state = stp_pkg::STP_TLR;
    endcase
  end

  // TMS taken on rising TCK only
  always_ff @(posedge i_tck or negedge i_resetn) begin
    if (!i_resetn) begin
      o_state <= stp_pkg::STP_TLR;
    end else begin
      o_state <= next_state;
    end
  end

  always_comb begin
    o_ir.capture = (o_state == stp_pkg::STP_CAP_IR);
    o_ir.shift = (o_state == stp_pkg::STP_SH_IR);
    o_ir.update = (o_state == stp_pkg::STP_UPD_IR);
    o_dr.capture = (o_state == stp_pkg::STP_CAP_DR);
    o_dr.shift = (o_state == stp_pkg::STP_SH_DR);
    o_dr.update = (o_state == stp_pkg::STP_UPD_DR);
  end

endmodule // stp_fsm
`default_nettype wire

// *** hdl/stp_sram_jtag_tap_port.sv ***
// Serial test access port of the SRAM: controller, instruction register,
// bypass, identification and boundary scan registers, and TDO driver.
// Assumes TCK comes from an external test controller and may stop; the
// memory core runs on i_clock and sees only the synchronised bus control.
//
// Behaviour
// - Port logic runs only on TCK, apart from the memory clock.
// - All port inputs are taken on rising TCK.
// - All port outputs except o_q_hiz change on falling TCK only; o_q_hiz follows the memory clock.
// - TMS on each rising TCK advances the controller.
// - Undriven TMS reads as one.
// - Undriven TDI reads as one.
// - Only the register chosen by the instruction sits between TDI, TDO.
// - TDI enters the most significant bit of the chosen register.
// - Power-up puts the port in reset, leaving memory operation alone.
// - Memory works fully when the port is never used.
// - Controller follows the standard sixteen-state machine.
// - TDO shows the chosen register's lowest bit, changing on falling TCK.
// - Instruction resets to identification at power-up and in reset state.
// - Instruction capture loads binary 01 into the lowest two bits.
`timescale 1ns/10ps
`default_nettype none
module stp_sram_jtag_tap_port #(
  parameter int BSR_LEN = stp_pkg::STP_BSR_LEN,
  parameter int HIZ_BIT = stp_pkg::STP_HIZ_BIT,
  parameter logic [31:0] IDCODE_VAL = stp_pkg::STP_IDCODE_VAL
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tms_en,
  input wire logic i_tdi,
  input wire logic i_tdi_en,
  input wire logic [BSR_LEN-1:0] i_ring,
  output logic o_tdo,
  output logic o_tdo_oe,
  output logic [BSR_LEN-1:0] o_ring_out,
  output logic o_ring_drive,
  output logic o_q_hiz
);

  localparam int IR_W = stp_pkg::STP_IR_W;
  localparam int ID_W = stp_pkg::STP_ID_W;

  // Instructions whose update-DR writes the boundary latch
  function automatic logic preload_ok(input logic [IR_W-1:0] code);
    preload_ok = (code == stp_pkg::STP_I_SAMPLE) ||
                 (code == stp_pkg::STP_I_EXTEST);
  endfunction

  logic tck_resetn;
  logic tms;
  logic tdi;
  logic [BSR_LEN-1:0] ring_sync;
  stp_pkg::stp_state_t state;
  stp_pkg::stp_ctl_t ir_ctl;
  stp_pkg::stp_ctl_t dr_ctl;
  stp_pkg::stp_dr_t dr_sel;
  logic [IR_W-1:0] ir_shift;
  logic [IR_W-1:0] instr;
  logic bypass;
  logic [ID_W-1:0] id_shift;
  logic [BSR_LEN-1:0] bsr_shift;
  logic q_hiz_tck;
  logic next_tdo;
  logic next_tdo_oe;
  logic next_q_hiz;
  logic [IR_W-1:0] next_instr;
  logic next_cell;
  logic dr_lsb;

  // Undriven pins read through the pull-ups
  assign tms = i_tms_en ? i_tms : 1'b1;
  assign tdi = i_tdi_en ? i_tdi : 1'b1;

  // Reset asserts at once but releases on TCK; a stopped TCK simply
  // leaves the port parked in reset, which is harmless
  stp_sync #(
    .WIDTH(1)
  ) u_rst_sync (
    .i_clock(i_tck),
    .i_resetn(i_resetn),
    .i_level(1'b1),
    .o_level(tck_resetn)
  );

  // Ring pins move with the memory clock, not TCK
  stp_sync #(
    .WIDTH(BSR_LEN)
  ) u_ring_sync (
    .i_clock(i_tck),
    .i_resetn(tck_resetn),
    .i_level(i_ring),
    .o_level(ring_sync)
  );

  stp_fsm u_fsm (
    .i_tck(i_tck),
    .i_resetn(tck_resetn),
    .i_tms(tms),
    .o_state(state),
    .o_ir(ir_ctl),
    .o_dr(dr_ctl)
  );

  assign dr_sel = stp_pkg::stp_dr_select(instr);

  // Instruction shift register on rising TCK
  always_ff @(posedge i_tck or negedge tck_resetn) begin
    if (!tck_resetn) begin
      ir_shift <= stp_pkg::STP_IR_CAPTURE;
    end else if (ir_ctl.capture) begin
      ir_shift <= stp_pkg::STP_IR_CAPTURE;
    end else if (ir_ctl.shift) begin
      ir_shift <= {tdi, ir_shift[IR_W-1:1]};
    end
  end

  // Next instruction and bus-control cell, so the bus control flops
  // switch on the same falling edge as the latches, never one late
  always_comb begin
    next_instr = instr;
    next_cell = o_ring_out[HIZ_BIT];
    if (state == stp_pkg::STP_TLR) begin
      next_instr = stp_pkg::STP_IR_RESET;
      next_cell = stp_pkg::STP_HIZ_CELL_RESET;
    end else if (ir_ctl.update) begin
      next_instr = ir_shift;
    end else if (dr_ctl.update && preload_ok(instr)) begin
      next_cell = bsr_shift[HIZ_BIT];
    end
  end

  // Active instruction changes on falling TCK, as the standard has it
  always_ff @(negedge i_tck or negedge tck_resetn) begin
    if (!tck_resetn) begin
      instr <= stp_pkg::STP_IR_RESET;
    end else begin
      instr <= next_instr;
    end
  end

  // Bypass cell
  always_ff @(posedge i_tck or negedge tck_resetn) begin
    if (!tck_resetn) begin
      bypass <= stp_pkg::STP_BYPASS_CAPTURE;
    end else if (dr_sel == stp_pkg::STP_DR_BYP) begin
      if (dr_ctl.capture) begin
        bypass <= stp_pkg::STP_BYPASS_CAPTURE;
      end else if (dr_ctl.shift) begin
        bypass <= tdi;
      end
    end
  end

  // Identification register
  always_ff @(posedge i_tck or negedge tck_resetn) begin
    if (!tck_resetn) begin
      id_shift <= IDCODE_VAL;
    end else if (dr_sel == stp_pkg::STP_DR_ID) begin
      if (dr_ctl.capture) begin
        id_shift <= IDCODE_VAL;
      end else if (dr_ctl.shift) begin
        id_shift <= {tdi, id_shift[ID_W-1:1]};
      end
    end
  end

  // Boundary scan shift stage
  always_ff @(posedge i_tck or negedge tck_resetn) begin
    if (!tck_resetn) begin
      bsr_shift <= '0;
    end else if (dr_sel == stp_pkg::STP_DR_BSR) begin
      if (dr_ctl.capture) begin
        bsr_shift <= ring_sync;
      end else if (dr_ctl.shift) begin
        bsr_shift <= {tdi, bsr_shift[BSR_LEN-1:1]};
      end
    end
  end

  // Boundary update latch; only preload-capable instructions load it at update-DR, and the reset state clears the bus cell
  always_ff @(negedge i_tck or negedge tck_resetn) begin
    if (!tck_resetn) begin
      o_ring_out <= '0;
    end else if (state == stp_pkg::STP_TLR) begin
      o_ring_out[HIZ_BIT] <= stp_pkg::STP_HIZ_CELL_RESET;
    end else if (dr_ctl.update) begin
      if (preload_ok(instr)) begin
        o_ring_out <= bsr_shift;
      end
    end
  end

  // Bus control follows the active instruction, on falling TCK
  always_comb begin
    next_q_hiz = 1'b0;
    case (next_instr)
      stp_pkg::STP_I_SAMPLE_Z: next_q_hiz = 1'b1;
      stp_pkg::STP_I_EXTEST: next_q_hiz = ~next_cell;
      default: next_q_hiz = 1'b0;
    endcase
  end

  always_ff @(negedge i_tck or negedge tck_resetn) begin
    if (!tck_resetn) begin
      q_hiz_tck <= 1'b0;
    end else begin
      q_hiz_tck <= next_q_hiz;
    end
  end

  // Drive follows the cell being latched, so it never outlives the cell
  always_ff @(negedge i_tck or negedge tck_resetn) begin
    if (!tck_resetn) begin
      o_ring_drive <= 1'b0;
    end else begin
      o_ring_drive <= (next_instr == stp_pkg::STP_I_EXTEST) &
                      next_cell;
    end
  end

  // Memory side sees the bus control only through a synchroniser
  stp_sync #(
    .WIDTH(1)
  ) u_hiz_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_level(q_hiz_tck),
    .o_level(o_q_hiz)
  );

  // Serial output path
  always_comb begin
    dr_lsb = bypass;
    case (dr_sel)
      stp_pkg::STP_DR_ID: dr_lsb = id_shift[0];
      stp_pkg::STP_DR_BSR: dr_lsb = bsr_shift[0];
      stp_pkg::STP_DR_BYP: dr_lsb = bypass;
      default: dr_lsb = bypass;
    endcase
  end

  always_comb begin
    next_tdo = 1'b0;
    next_tdo_oe = 1'b0;
    if (ir_ctl.shift) begin
      next_tdo = ir_shift[0];
      next_tdo_oe = 1'b1;
    end else if (dr_ctl.shift) begin
      next_tdo = dr_lsb;
      next_tdo_oe = 1'b1;
    end
  end

  // Falling edge gives the controller half a period of hold
  always_ff @(negedge i_tck or negedge tck_resetn) begin
    if (!tck_resetn) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      o_tdo <= next_tdo;
      o_tdo_oe <= next_tdo_oe;
    end
  end

endmodule // stp_sram_jtag_tap_port
`default_nettype wire

// *** testbench/stp_tap_assertions.sv ***
// Port checker for the SRAM test port.
// Assumes an undriven TMS pin reads as one.
`timescale 1ns/10ps
`default_nettype none
module stp_tap_assertions #(
  parameter int BSR_LEN = 110,
  parameter int HIZ_BIT = 109
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tms_en,
  input wire logic o_tdo,
  input wire logic o_tdo_oe,
  input wire logic [BSR_LEN-1:0] o_ring_out,
  input wire logic o_ring_drive,
  input wire logic o_q_hiz
);
  logic tms1;
  logic [1:0] at_rise;
  assign tms1 = !i_tms_en || i_tms;
  // Seen at rise; a change made at rise shows up by the fall
  always_ff @(posedge i_tck or negedge i_resetn) begin
    if (!i_resetn) begin
      at_rise <= 2'h0;
    end else begin
      at_rise <= {o_tdo_oe, o_tdo};
    end
  end
  a_tdo_fall_only: assert property (
    @(negedge i_tck) disable iff (!i_resetn) o_tdo == at_rise[0])
    else $error("tdo moved at rising tck");
  a_oe_fall_only: assert property (
    @(negedge i_tck) disable iff (!i_resetn) o_tdo_oe == at_rise[1])
    else $error("tdo enable moved at rising tck");
  a_oe_off_tms1: assert property (
    @(posedge i_tck) disable iff (!i_resetn) tms1 |=> !o_tdo_oe)
    else $error("tdo driven outside shift");
  a_oe_after_tms0: assert property (
    @(posedge i_tck) disable iff (!i_resetn) $rose(o_tdo_oe) |-> !$past(tms1))
    else $error("shift entered without tms low");
  a_tdo_low_idle: assert property (
    @(posedge i_tck) disable iff (!i_resetn) !o_tdo_oe |-> !o_tdo)
    else $error("tdo not low while released");
  a_tlr_clears_cell: assert property (
    @(posedge i_tck) disable iff (!i_resetn)
    tms1 [*5] |=> !o_ring_out[HIZ_BIT] && !o_ring_drive)
    else $error("five tms ones left ring drive");
  a_drive_needs_cell: assert property (
    @(posedge i_tck) disable iff (!i_resetn)
    o_ring_drive |-> o_ring_out[HIZ_BIT])
    else $error("ring driven with cell low");
  a_hiz_vs_drive: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    o_ring_drive [*4] |-> !o_q_hiz)
    else $error("bus high-z while ring drives");
  a_reset_quiet: assert property (
    @(posedge i_clock) !i_resetn |-> !o_tdo_oe && !o_tdo && !o_q_hiz &&
    !o_ring_drive && o_ring_out == '0)
    else $error("outputs active in reset");
endmodule // stp_tap_assertions
bind stp_sram_jtag_tap_port stp_tap_assertions #(
  .BSR_LEN(BSR_LEN), .HIZ_BIT(HIZ_BIT)) i_stp_tap_assertions (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_tck(i_tck), .i_tms(i_tms),
  .i_tms_en(i_tms_en), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
  .o_ring_out(o_ring_out), .o_ring_drive(o_ring_drive),
  .o_q_hiz(o_q_hiz));
`default_nettype wire

// *** testbench/stp_jtag_ctrl.sv ***
// Model of the scan controller facing the test port.
// Assumes TDO settles within half a TCK period.
`timescale 1ns/10ps
`default_nettype none
module stp_jtag_ctrl (
  output logic o_tck,
  output logic o_tms,
  output logic o_tms_en,
  output logic o_tdi,
  output logic o_tdi_en,
  input wire logic i_tdo,
  input wire logic i_tdo_oe
);
  localparam logic L = 1'b0;
  localparam logic H = 1'b1;
  // TCK stands low between frames
  initial begin
    o_tck = L;
    o_tms = H;
    o_tms_en = L;
    o_tdi = H;
    o_tdi_en = L;
  end
  task automatic step(input logic m, input logic d, input logic dm,
                      input logic dd, output logic q, output logic e);
    o_tms_en = dm;
    o_tdi_en = dd;
    // Released pins carry junk; only the pull-ups may decide
    o_tms = dm ? m : ~o_tms;
    o_tdi = dd ? d : ~o_tdi;
    #3 o_tck = H;
    q = i_tdo;
    e = i_tdo_oe;
    #3 o_tck = L;
  endtask
  task automatic tlr();
    logic q, e;
    #1.7;
    repeat (5) step(L, L, L, H, q, e);
    step(L, L, H, H, q, e);
  endtask
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      input logic dd, output logic [127:0] dout,
                      output logic ok);
    logic q, e;
    dout = '0;
    ok = H;
    #1.3;
    // Idle clocks let the ring synchroniser catch up
    repeat (2) step(L, L, H, H, q, e);
    step(H, L, H, H, q, e);
    if (ir) step(H, L, H, H, q, e);
    repeat (2) step(L, L, H, H, q, e);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], H, dd, q, e);
      dout[i] = q;
      ok &= e;
    end
    step(H, L, H, H, q, e);
    step(L, L, H, H, q, e);
  endtask
endmodule // stp_jtag_ctrl
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the SRAM test port.
// Assumes the controller model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int N = stp_pkg::STP_BSR_LEN;
  localparam int HZ = stp_pkg::STP_HIZ_BIT;
  localparam logic [31:0] ID = stp_pkg::STP_IDCODE_VAL;
  logic i_clock, i_resetn, tck, tms, tms_en, tdi, tdi_en;
  logic tdo, tdo_oe, drive, q_hiz, ok;
  logic [N-1:0] ring, ring_out;
  logic [127:0] din, dout;
  logic [31:0] seed;
  logic [2:0] codes [4];
  int fail_count, n_compared;
  stp_jtag_ctrl i_stp_jtag_ctrl (.o_tck(tck), .o_tms(tms),
    .o_tms_en(tms_en), .o_tdi(tdi), .o_tdi_en(tdi_en), .i_tdo(tdo),
    .i_tdo_oe(tdo_oe));
  stp_sram_jtag_tap_port i_stp_sram_jtag_tap_port (.i_clock(i_clock),
    .i_resetn(i_resetn), .i_tck(tck), .i_tms(tms), .i_tms_en(tms_en),
    .i_tdi(tdi), .i_tdi_en(tdi_en), .i_ring(ring), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe), .o_ring_out(ring_out), .o_ring_drive(drive),
    .o_q_hiz(q_hiz));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  function automatic logic [127:0] rnd();
    logic [127:0] r;
    repeat (4) begin
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      r = {r[95:0], seed};
    end
    return r;
  endfunction
  // Bypass: captured zero first, then the sent bits one place late
  function automatic logic [127:0] byp(input logic [127:0] d, input int n);
    return {d[126:0], 1'b0} & ((128'h1 << n) - 128'h1);
  endfunction
  task automatic chk(input string s, input logic [127:0] seen,
                     input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic ir(input logic [2:0] c);
    i_stp_jtag_ctrl.scan(1'b1, 3, 128'(c), 1'b1, dout, ok);
  endtask
  task automatic dr(input int n, input logic [127:0] d);
    i_stp_jtag_ctrl.scan(1'b0, n, d, 1'b1, dout, ok);
  endtask
  task automatic clks(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
  initial begin
    // Start high so the async reset sees a clean falling edge
    i_resetn = 1'b1;
    ring = '0;
    seed = 32'h0000_07b5;
    fail_count = 0;
    n_compared = 0;
    codes = '{3'h7, 3'h3, 3'h5, 3'h6};
    #1 i_resetn = 1'b0;
    clks(20);
    i_resetn = 1'b1;
    chk("oe_idle", 128'(tdo_oe), '0);
    i_stp_jtag_ctrl.tlr();
    dr(32, '1);
    chk("idcode", dout, 128'(ID));
    chk("id_oe", 128'(ok), 128'h1);
    ir(stp_pkg::STP_I_BYPASS);
    chk("ir_capture", dout, 128'(stp_pkg::STP_IR_CAPTURE));
    i_stp_jtag_ctrl.scan(1'b0, 2, '0, 1'b0, dout, ok);
    chk("tdi_float", dout, 128'h2);
    $display("test reset_id done");
    foreach (codes[k]) begin
      ir(codes[k]);
      din = rnd();
      dr(40, din);
      chk("bypass", dout, byp(din, 40));
    end
    $display("test bypass done");
    ir(stp_pkg::STP_I_SAMPLE);
    din = rnd();
    clks(1);
    ring = din[N-1:0];
    din = rnd();
    din[HZ] = 1'b1;
    dr(N, din);
    chk("ring_capture", dout, 128'(ring));
    chk("preload", 128'(ring_out), 128'(din[N-1:0]));
    ir(stp_pkg::STP_I_SAMPLE_Z);
    clks(5);
    chk("sample_z", 128'({drive, q_hiz}), 128'h1);
    ir(stp_pkg::STP_I_EXTEST);
    clks(5);
    chk("drive", 128'({drive, q_hiz}), 128'h2);
    din[HZ] = 1'b0;
    dr(N, din);
    clks(5);
    chk("extest_off", 128'({drive, q_hiz}), 128'h1);
    din[HZ] = 1'b1;
    dr(N, din);
    chk("extest_capture", dout, 128'(ring));
    clks(5);
    chk("extest_on", 128'({drive, q_hiz}), 128'h2);
    $display("test ring done");
    i_stp_jtag_ctrl.tlr();
    clks(5);
    chk("tlr_cell", 128'({ring_out[HZ], q_hiz}), '0);
    dr(32, rnd());
    chk("tlr_id", dout, 128'(ID));
    ir(stp_pkg::STP_I_EXTEST);
    clks(5);
    chk("hiz_cell", 128'({drive, q_hiz}), 128'h1);
    i_resetn = 1'b0;
    clks(3);
    chk("reset", 128'({tdo_oe, drive, q_hiz}), '0);
    i_resetn = 1'b1;
    i_stp_jtag_ctrl.tlr();
    dr(32, '0);
    chk("reset_id", dout, 128'(ID));
    $display("test tap_reset done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
